// ### pkg/rie_pkg.sv
// constants for the reset and interrupt exception unit
package rie_pkg;
	// source counts
	localparam int RIE_N_PRIO_EXT = 4;            // priority external requests
	localparam int RIE_N_SHARED_EXT = 8;          // shared external requests
	localparam int RIE_N_EXT = 12;                // all external requests
	localparam int RIE_N_INT = 21;                // peripheral requests
	localparam int RIE_N_GRP = 13;                // vector groups that can be serviced
	localparam int RIE_WDT_WIDTH = 8;             // watchdog counter width
	// peripheral request bit positions
	localparam int RIE_IB_TIMER_A = 0;            // timer A overflow
	localparam int RIE_IB_UNIT_A = 1;             // unit_a overflow
	localparam int RIE_IB_CAP_LO = 2;             // capture timer, seven events
	localparam int RIE_IB_CAP_HI = 8;
	localparam int RIE_IB_CMP_LO = 9;             // compare timer, three events
	localparam int RIE_IB_CMP_HI = 11;
	localparam int RIE_IB_CSU = 12;               // clocked_serial_unit
	localparam int RIE_IB_ASU_LO = 13;            // async_serial_unit, six events
	localparam int RIE_IB_ASU_HI = 18;
	localparam int RIE_IB_ADC = 19;               // conversion end
	localparam int RIE_IB_DXFER = 20;             // sleep-time direct transfer
	// vector numbers per group, listed lowest priority first (group 0, listed last, is highest)
	localparam logic [4:0] RIE_VEC_RESET = 5'h00;
	localparam logic [RIE_N_GRP-1:0][4:0] RIE_GRP_VEC = {
		5'h17, 5'h16, 5'h15, 5'h13, 5'h11, 5'h10, 5'h0b, 5'h0a, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04};
	// vector table addresses are two bytes per entry
	localparam int RIE_VEC_SHIFT = 1;
	// register byte offsets on the bus
	localparam logic [7:0] RIE_REG_EDGE_SEL = 8'h00;
	localparam logic [7:0] RIE_REG_EXT_EN = 8'h04;
	localparam logic [7:0] RIE_REG_INT_EN = 8'h08;
	localparam logic [7:0] RIE_REG_EXT_FLAG = 8'h0c;
	localparam logic [7:0] RIE_REG_INT_FLAG = 8'h10;
	localparam logic [7:0] RIE_REG_WDT = 8'h14;
	localparam logic [7:0] RIE_REG_STATUS = 8'h18;
	// watchdog_ctrl_status fields
	localparam int RIE_WDT_RUN_BIT = 0;           // watchdog_run_enable
	localparam int RIE_WDT_FLAG_BIT = 1;          // watchdog_reset_flag
	localparam int RIE_WDT_CNT_LSB = 8;           // counter readback
	// status fields
	localparam int RIE_ST_VEC_LSB = 8;            // last issued vector
	localparam int RIE_ST_FIRST_BIT = 4;          // first instruction still due
	// reset values
	localparam logic [RIE_N_EXT-1:0] RIE_EXT_RST = 12'h000;
	localparam logic [RIE_N_INT-1:0] RIE_INT_RST = 21'h000000;
	localparam logic [31:0] RIE_RD_ZERO = 32'h00000000;
	// sequencer states
	typedef enum logic [1:0] {
		RIE_ST_RESET,
		RIE_ST_RESET_EXC,
		RIE_ST_RUN,
		RIE_ST_INT_EXC
	} rie_state_t;
endpackage

// ### core/rie_unit.sv
// reset and interrupt exception sequencer with watchdog and wishbone registers
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
// Behaviour
// - reset outranks interrupts, starts on release
// - interrupts only at instruction boundary
// - reset pin low halts everything
// - reset exception starts on pin release
// - reset initialises registers, sets mask bit
// - program counter loaded from vector zero
// - watchdog counts up when run enabled
// - watchdog overflow sets flag, resets chip
// - next overflow with flag releases reset
// - first instruction runs before any interrupt
// - twelve external, twentyone internal requests
// - highest fixed priority pending source serviced
// - mask bit blocks acceptance, flags still set
// - each external edge rising or falling
// - fixed vector numbers, priority by number
// - capture timer events share vector sixteen
// - compare timer events share vector seventeen
// - async serial events share vector twentyone
// - reserved vector slots never issued
// - flags cleared by writing zero only
module rie_unit #(
	parameter int WDT_WIDTH = rie_pkg::RIE_WDT_WIDTH
) (
	input  wire logic                          sys_clk,
	input  wire logic                          resetn,
	input  wire logic                          ext_reset_pin_n,
	input  wire logic [rie_pkg::RIE_N_PRIO_EXT-1:0]   priority_ext_requests,
	input  wire logic [rie_pkg::RIE_N_SHARED_EXT-1:0] shared_ext_requests,
	input  wire logic [rie_pkg::RIE_N_INT-1:0] periph_events,
	input  wire logic                          core_mask_bit,
	input  wire logic                          core_instr_done,
	input  wire logic                          core_exc_done,
	output logic                               core_reset,
	output logic                               cond_mask_set,
	output logic                               exc_req,
	output logic [4:0]                         exc_vector_num,
	output logic [5:0]                         exc_vector_addr,
	output logic                               wb_ack_o,
	output logic [31:0]                        wb_dat_o,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [7:0]                    wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i
);
	localparam int NE = rie_pkg::RIE_N_EXT;
	localparam int NI = rie_pkg::RIE_N_INT;
	localparam int NG = rie_pkg::RIE_N_GRP;

	// counter must fit its readback field
	// a full 24-bit counter would leave an empty pad in the readback word
	if (WDT_WIDTH < 2 || WDT_WIDTH > 23) begin : g_wdt_chk
		$error("WDT_WIDTH must lie between 2 and 23");
	end

	logic                   rst_meta;          // reset pin, first stage
	logic                   rst_sync;          // reset pin, usable level
	logic [NE-1:0]          ext_meta;          // external pins, first stage
	logic [NE-1:0]          ext_sync;          // external pins, second stage
	logic [NE-1:0]          ext_prev;          // previous synchronised level
	logic [NE-1:0]          edge_sel;          // 1 = rising edge
	logic [NE-1:0]          ext_en;            // external enables
	logic [NI-1:0]          int_en;            // peripheral enables
	logic [NE-1:0]          ext_flag;          // external request flags
	logic [NI-1:0]          int_flag;          // peripheral request flags
	logic                   wdt_run;           // watchdog_run_enable
	logic                   wdt_flag;          // watchdog_reset_flag
	logic                   wdt_hold;          // watchdog keeps chip in reset
	logic [WDT_WIDTH-1:0]   wdt_count;         // watchdog_counter
	logic                   first_pending;     // first instruction not yet done
	rie_pkg::rie_state_t    state;             // sequencer state
	rie_pkg::rie_state_t    next_state;

	// pin reset and synchroniser
	// two stage sync
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
			ext_meta <= '1;
			ext_sync <= '1;
			ext_prev <= '1;
		end else begin
			rst_meta <= ext_reset_pin_n;
			rst_sync <= rst_meta;
			ext_meta <= {shared_ext_requests, priority_ext_requests};
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	// chip reset: pin or watchdog, outranks everything
	wire pin_rst = ~rst_sync;
	wire chip_rst = pin_rst | wdt_hold;

	// edge detection, one event per qualifying edge
	wire [NE-1:0] ext_rise = ext_sync & ~ext_prev;
	wire [NE-1:0] ext_fall = ~ext_sync & ext_prev;
	wire [NE-1:0] ext_evt = (edge_sel & ext_rise) | (~edge_sel & ext_fall);

	// bus decode
	wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        bus_wr = bus_req & wb_we_i;
	wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] wr_new = wb_dat_i & byte_mask;
	wire        wr_edge = bus_wr & (wb_adr_i == rie_pkg::RIE_REG_EDGE_SEL);
	wire        wr_ext_en = bus_wr & (wb_adr_i == rie_pkg::RIE_REG_EXT_EN);
	wire        wr_int_en = bus_wr & (wb_adr_i == rie_pkg::RIE_REG_INT_EN);
	wire        wr_ext_fl = bus_wr & (wb_adr_i == rie_pkg::RIE_REG_EXT_FLAG);
	wire        wr_int_fl = bus_wr & (wb_adr_i == rie_pkg::RIE_REG_INT_FLAG);
	wire        wr_wdt = bus_wr & (wb_adr_i == rie_pkg::RIE_REG_WDT);
	// a zero in an enabled byte lane clears, everything else keeps
	wire [31:0] clr_keep = wb_dat_i | ~byte_mask;
	wire [NE-1:0] ext_keep = wr_ext_fl ? clr_keep[NE-1:0] : '1;
	wire [NI-1:0] int_keep = wr_int_fl ? clr_keep[NI-1:0] : '1;

	// interrupt configuration, cleared by any chip reset
	// peripheral registers initialised
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			edge_sel <= rie_pkg::RIE_EXT_RST;
			ext_en <= rie_pkg::RIE_EXT_RST;
			int_en <= rie_pkg::RIE_INT_RST;
		end else if (chip_rst) begin
			edge_sel <= rie_pkg::RIE_EXT_RST;
			ext_en <= rie_pkg::RIE_EXT_RST;
			int_en <= rie_pkg::RIE_INT_RST;
		end else begin
			if (wr_edge) begin
				edge_sel <= wr_new[NE-1:0] | (edge_sel & ~byte_mask[NE-1:0]);
			end
			if (wr_ext_en) begin
				ext_en <= wr_new[NE-1:0] | (ext_en & ~byte_mask[NE-1:0]);
			end
			if (wr_int_en) begin
				int_en <= wr_new[NI-1:0] | (int_en & ~byte_mask[NI-1:0]);
			end
		end
	end

	// request flags: set regardless of mask, set beats a clear
	// flags set while masked
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ext_flag <= rie_pkg::RIE_EXT_RST;
			int_flag <= rie_pkg::RIE_INT_RST;
		end else if (chip_rst) begin
			ext_flag <= rie_pkg::RIE_EXT_RST;
			int_flag <= rie_pkg::RIE_INT_RST;
		end else begin
			ext_flag <= (ext_flag & ext_keep) | ext_evt;
			int_flag <= (int_flag & int_keep) | periph_events;
		end
	end

	// watchdog: pin reset clears it, its own reset does not
	wire wdt_ovf = wdt_run & (&wdt_count);
	wire wdt_enter = wdt_ovf & ~wdt_hold;
	wire wdt_leave = wdt_ovf & wdt_hold & wdt_flag;
	// flag clear only by writing zero, never while reset held
	wire wdt_flag_clr = wr_wdt & wb_sel_i[0] & ~wb_dat_i[rie_pkg::RIE_WDT_FLAG_BIT] & ~wdt_hold;

	// watchdog counter and control
	// count while enabled
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wdt_count <= '0;
			wdt_run <= 1'b0;
			wdt_flag <= 1'b0;
			wdt_hold <= 1'b0;
		end else if (pin_rst) begin
			wdt_count <= '0;
			wdt_run <= 1'b0;
			wdt_flag <= 1'b0;
			wdt_hold <= 1'b0;
		end else begin
			if (wdt_run) begin
				wdt_count <= wdt_count + 1'b1;
			end
			if (wr_wdt && wb_sel_i[0] && !wdt_hold) begin
				wdt_run <= wb_dat_i[rie_pkg::RIE_WDT_RUN_BIT];
			end
			// set wins over a clear in the same cycle
			wdt_flag <= wdt_enter | (wdt_flag & ~wdt_flag_clr);
			wdt_hold <= wdt_enter | (wdt_hold & ~wdt_leave);
		end
	end

	// pending requests folded into vector groups
	// all 33 sources
	wire [NE-1:0] ext_pend = ext_flag & ext_en;
	wire [NI-1:0] int_pend = int_flag & int_en;
	wire [NG-1:0] grp_pend;
	assign grp_pend[3:0] = ext_pend[rie_pkg::RIE_N_PRIO_EXT-1:0];
	assign grp_pend[4] = |ext_pend[NE-1:rie_pkg::RIE_N_PRIO_EXT];
	assign grp_pend[5] = int_pend[rie_pkg::RIE_IB_TIMER_A];
	assign grp_pend[6] = int_pend[rie_pkg::RIE_IB_UNIT_A];
	assign grp_pend[7] = |int_pend[rie_pkg::RIE_IB_CAP_HI:rie_pkg::RIE_IB_CAP_LO];
	assign grp_pend[8] = |int_pend[rie_pkg::RIE_IB_CMP_HI:rie_pkg::RIE_IB_CMP_LO];
	assign grp_pend[9] = int_pend[rie_pkg::RIE_IB_CSU];
	assign grp_pend[10] = |int_pend[rie_pkg::RIE_IB_ASU_HI:rie_pkg::RIE_IB_ASU_LO];
	assign grp_pend[11] = int_pend[rie_pkg::RIE_IB_ADC];
	assign grp_pend[12] = int_pend[rie_pkg::RIE_IB_DXFER];

	// fixed priority pick, lowest group index wins
	// highest priority only
	logic [4:0] pick_vec;
	always_comb begin
		pick_vec = rie_pkg::RIE_GRP_VEC[0];
		for (int g = NG - 1; g >= 0; g--) begin
			if (grp_pend[g]) begin
				pick_vec = rie_pkg::RIE_GRP_VEC[g];
			end
		end
	end

	// acceptance point: between instructions, unmasked, not first one
	// boundary only
	wire accept = (state == rie_pkg::RIE_ST_RUN) & core_instr_done & ~core_mask_bit
		& ~first_pending & (|grp_pend);

	// sequencer next state
	always_comb begin
		next_state = state;
		unique case (state)
			rie_pkg::RIE_ST_RESET: begin
				next_state = rie_pkg::RIE_ST_RESET_EXC;
			end
			rie_pkg::RIE_ST_RESET_EXC: begin
				if (core_exc_done) begin
					next_state = rie_pkg::RIE_ST_RUN;
				end
			end
			rie_pkg::RIE_ST_RUN: begin
				if (accept) begin
					next_state = rie_pkg::RIE_ST_INT_EXC;
				end
			end
			rie_pkg::RIE_ST_INT_EXC: begin
				if (core_exc_done) begin
					next_state = rie_pkg::RIE_ST_RUN;
				end
			end
		endcase
		if (chip_rst) begin
			next_state = rie_pkg::RIE_ST_RESET;
		end
	end

	// vector chosen for the next exception
	// table vectors only
	wire [4:0] next_vec = (next_state == rie_pkg::RIE_ST_INT_EXC && accept) ? pick_vec
		: (next_state == rie_pkg::RIE_ST_RESET_EXC) ? rie_pkg::RIE_VEC_RESET : exc_vector_num;

	// sequencer registers and core-facing outputs
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= rie_pkg::RIE_ST_RESET;
			core_reset <= 1'b1;
			cond_mask_set <= 1'b1;
			exc_req <= 1'b0;
			exc_vector_num <= rie_pkg::RIE_VEC_RESET;
			exc_vector_addr <= '0;
		end else begin
			state <= next_state;
			core_reset <= (next_state == rie_pkg::RIE_ST_RESET);
			cond_mask_set <= (next_state == rie_pkg::RIE_ST_RESET)
				| (next_state == rie_pkg::RIE_ST_RESET_EXC);
			exc_req <= (next_state == rie_pkg::RIE_ST_RESET_EXC) | (next_state == rie_pkg::RIE_ST_INT_EXC);
			exc_vector_num <= next_vec;
			exc_vector_addr <= {next_vec, 1'b0};
		end
	end

	// first instruction guard, armed by reset handling
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			first_pending <= 1'b1;
		end else if (state != rie_pkg::RIE_ST_RUN) begin
			first_pending <= (state != rie_pkg::RIE_ST_INT_EXC) | first_pending;
		end else if (core_instr_done) begin
			first_pending <= 1'b0;
		end
	end

	// read mux, unmapped offsets read zero
	wire [31:0] rd_wdt = {{(24 - WDT_WIDTH){1'b0}}, wdt_count, 6'h00, wdt_flag, wdt_run};
	wire [31:0] rd_stat = {19'h00000, exc_vector_num, 3'h0, first_pending, 2'h0, state};
	wire [31:0] rd_data =
		(wb_adr_i == rie_pkg::RIE_REG_EDGE_SEL) ? {20'h00000, edge_sel} :
		(wb_adr_i == rie_pkg::RIE_REG_EXT_EN) ? {20'h00000, ext_en} :
		(wb_adr_i == rie_pkg::RIE_REG_INT_EN) ? {11'h000, int_en} :
		(wb_adr_i == rie_pkg::RIE_REG_EXT_FLAG) ? {20'h00000, ext_flag} :
		(wb_adr_i == rie_pkg::RIE_REG_INT_FLAG) ? {11'h000, int_flag} :
		(wb_adr_i == rie_pkg::RIE_REG_WDT) ? rd_wdt :
		(wb_adr_i == rie_pkg::RIE_REG_STATUS) ? rd_stat : rie_pkg::RIE_RD_ZERO;

	// single wait-state slave, ack for one cycle
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= rie_pkg::RIE_RD_ZERO;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_data : rie_pkg::RIE_RD_ZERO;
		end
	end

	// checks
	property p_reset_wins;
		@(posedge sys_clk) disable iff (!resetn)
		chip_rst |=> (state == rie_pkg::RIE_ST_RESET) && core_reset;
	endproperty
	a_reset_wins: assert property (p_reset_wins) else $error("reset did not take precedence");

	property p_release;
		@(posedge sys_clk) disable iff (!resetn)
		(state == rie_pkg::RIE_ST_RESET) && !chip_rst |=> exc_req && cond_mask_set && exc_vector_addr == 6'h00;
	endproperty
	a_release: assert property (p_release) else $error("reset handling did not start with vector zero");

	property p_wdt_count;
		@(posedge sys_clk) disable iff (!resetn)
		wdt_run && !pin_rst |=> wdt_count == $past(wdt_count) + 1'b1;
	endproperty
	a_wdt_count: assert property (p_wdt_count) else $error("watchdog counter did not advance");

	property p_wdt_enter;
		@(posedge sys_clk) disable iff (!resetn)
		wdt_enter && !pin_rst |=> wdt_hold && wdt_flag ##1 core_reset;
	endproperty
	a_wdt_enter: assert property (p_wdt_enter) else $error("watchdog overflow did not reset chip");

	property p_wdt_leave;
		@(posedge sys_clk) disable iff (!resetn)
		wdt_leave && rst_sync |=> !wdt_hold ##1 (state == rie_pkg::RIE_ST_RESET_EXC);
	endproperty
	a_wdt_leave: assert property (p_wdt_leave) else $error("second overflow did not release reset");

	property p_first;
		@(posedge sys_clk) disable iff (!resetn)
		$rose(state == rie_pkg::RIE_ST_RUN) && $past(state) == rie_pkg::RIE_ST_RESET_EXC |-> first_pending && !accept;
	endproperty
	a_first: assert property (p_first) else $error("interrupt taken before first instruction");

	property p_masked;
		@(posedge sys_clk) disable iff (!resetn)
		core_mask_bit || !core_instr_done |-> !accept;
	endproperty
	a_masked: assert property (p_masked) else $error("interrupt accepted while masked or mid instruction");

	property p_reserved;
		@(posedge sys_clk) disable iff (!resetn)
		exc_req |-> !(exc_vector_num inside {[5'h01:5'h03], 5'h09, [5'h0c:5'h0f], 5'h12, 5'h14});
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved vector issued");

	property p_write_one;
		@(posedge sys_clk) disable iff (!resetn)
		wr_int_fl && !chip_rst && !int_flag[0] && wb_dat_i[0] && wb_sel_i[0] && !periph_events[0] |=> !int_flag[0];
	endproperty
	a_write_one: assert property (p_write_one) else $error("writing one set a request flag");

	property p_vec_hold;
		@(posedge sys_clk) disable iff (!resetn)
		exc_req && !core_exc_done && !chip_rst |=> exc_req && $stable(exc_vector_num);
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("exception request dropped before completion");
endmodule

// ### testbench/rie_core_model.sv
// behavioural core model on the far side of the exception link
`timescale 1ns/100ps
module rie_core_model (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic core_reset,
	input  wire logic cond_mask_set,
	input  wire logic exc_req,
	input  wire logic run,
	input  wire logic slow,
	input  wire logic unmask,
	output logic      core_mask_bit,
	output logic      core_instr_done,
	output logic      core_exc_done
);
	logic [3:0] cnt;      // cycles into instruction or vector fetch
	logic       exc_seen; // exc_req one cycle ago
	logic       answered; // vector fetch already reported

	// mask set by reset handling and on every exception entry, as a real core does
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			core_mask_bit <= 1'b1;
		end else if (cond_mask_set || (exc_req && !exc_seen)) begin
			core_mask_bit <= 1'b1;
		end else if (unmask) begin
			core_mask_bit <= 1'b0;
		end
	end

	// instruction boundaries every four cycles, vector fetch fast or slow
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 4'h0;
			exc_seen <= 1'b0;
			answered <= 1'b0;
			core_instr_done <= 1'b0;
			core_exc_done <= 1'b0;
		end else begin
			exc_seen <= exc_req;
			core_instr_done <= 1'b0;
			core_exc_done <= 1'b0;
			cnt <= cnt + 4'h1;
			if (exc_req && !exc_seen) begin
				// restart timing at exception entry
				cnt <= 4'h0;
			end else if (exc_req && !answered) begin
				if (cnt >= (slow ? 4'h6 : 4'h1)) begin
					core_exc_done <= 1'b1;
					answered <= 1'b1;
				end
			end else if (!exc_req) begin
				answered <= 1'b0;
				// no instructions run while the chip is in reset
				if (run && !core_reset && cnt >= 4'h3) begin
					core_instr_done <= 1'b1;
					cnt <= 4'h0;
				end
			end
		end
	end
endmodule

// ### testbench/testbench.sv
// self-checking bench for the reset and interrupt exception unit
`timescale 1ns/100ps
module testbench;
	localparam int WDT_W = 4;       // short watchdog period for simulation
	logic        sys_clk;           // 125 MHz system clock
	logic        resetn;            // bench reset
	logic        ext_reset_pin_n;   // external reset pin
	logic [3:0]  prio_pins;         // priority request pins, idle high
	logic [7:0]  shared_pins;       // shared request pins, idle high
	logic [20:0] periph_events;     // peripheral event pulses
	logic        core_mask_bit;     // core mask bit from model
	logic        core_instr_done;   // instruction boundary pulse
	logic        core_exc_done;     // vector fetch done pulse
	logic        core_reset;        // chip in reset
	logic        cond_mask_set;     // mask forced by reset handling
	logic        exc_req;           // exception request to core
	logic [4:0]  exc_vector_num;    // vector number
	logic [5:0]  exc_vector_addr;   // vector byte address
	logic        wb_ack_o;          // bus answer
	logic [31:0] wb_dat_o;          // bus read data
	logic        wb_cyc_i;          // bus cycle
	logic        wb_stb_i;          // bus strobe
	logic        wb_we_i;           // bus direction
	logic [7:0]  wb_adr_i;          // bus byte address
	logic [3:0]  wb_sel_i;          // byte lanes
	logic [31:0] wb_dat_i;          // bus write data
	logic [31:0] rd;                // last read data
	logic        run;               // model executes instructions
	logic        slow;              // model fetches vectors slowly
	logic        unmask;            // model clears its mask bit
	int          failures;          // mismatches
	int          cmp_count;         // comparisons
	// expected vectors and flag bits per group, highest priority first
	logic [4:0]  exp_vec [13] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0b, 5'h10, 5'h11, 5'h13,
		5'h15, 5'h16, 5'h17};
	logic [11:0] grp_ext [13] = '{12'h001, 12'h002, 12'h004, 12'h008, 12'hff0, 12'h000, 12'h000, 12'h000,
		12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
	logic [20:0] grp_int [13] = '{21'h0, 21'h0, 21'h0, 21'h0, 21'h0, 21'h000001, 21'h000002, 21'h0001fc,
		21'h000e00, 21'h001000, 21'h07e000, 21'h080000, 21'h100000};

	// free-running clock
	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;

	rie_unit #(.WDT_WIDTH(WDT_W)) dut_u (.sys_clk(sys_clk), .resetn(resetn), .ext_reset_pin_n(ext_reset_pin_n),
		.priority_ext_requests(prio_pins), .shared_ext_requests(shared_pins), .periph_events(periph_events),
		.core_mask_bit(core_mask_bit), .core_instr_done(core_instr_done), .core_exc_done(core_exc_done),
		.core_reset(core_reset), .cond_mask_set(cond_mask_set), .exc_req(exc_req),
		.exc_vector_num(exc_vector_num), .exc_vector_addr(exc_vector_addr), .wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));

	rie_core_model core_u (.sys_clk(sys_clk), .resetn(resetn), .core_reset(core_reset),
		.cond_mask_set(cond_mask_set), .exc_req(exc_req), .run(run), .slow(slow), .unmask(unmask),
		.core_mask_bit(core_mask_bit), .core_instr_done(core_instr_done), .core_exc_done(core_exc_done));

	// compare and count
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		check("bus ack", wb_ack_o, 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// bounded wait for exc_req to reach a level
	task automatic wait_exc(input logic lvl, input int lim);
		int n;
		n = 0;
		while (exc_req !== lvl && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		check("exc_req", exc_req, lvl);
	endtask

	// one-cycle request to the model to clear its mask
	task automatic unmask_core();
		@(posedge sys_clk);
		unmask <= 1'b1;
		@(posedge sys_clk);
		unmask <= 1'b0;
	endtask

	// pin reset and the reset handling that follows it
	task automatic pin_reset();
		@(posedge sys_clk);
		ext_reset_pin_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		check("pin reset", core_reset, 1'b1);
		check("no exc in reset", exc_req, 1'b0);
		ext_reset_pin_n <= 1'b1;
		wait_exc(1'b1, 20);
		check("reset vector", exc_vector_num, 5'h00);
		check("reset addr", exc_vector_addr, 6'h00);
		check("reset mask", cond_mask_set, 1'b1);
		wait_exc(1'b0, 30);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// whole run is a few hundred cycles; this is far beyond it
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		end_of_test();
	end

	initial begin
		failures = 0;
		cmp_count = 0;
		resetn = 1'b0;
		ext_reset_pin_n = 1'b0;
		prio_pins = 4'hf;
		shared_pins = 8'hff;
		periph_events = 21'h0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hf;
		{run, slow, unmask} = 3'b000;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		check("mask in reset", cond_mask_set, 1'b1);
		pin_reset();
		// reset values, status with first instruction due, unmapped offset
		for (int a = 0; a < 8; a++) begin
			wb(1'b0, 8'(a * 4), 32'h0);
			check("reset value", rd, (a == 6) ? 32'h12 : 32'h0);
		end
		wb(1'b1, 8'h08, 32'h1fffff);
		wb(1'b1, 8'h04, 32'hfff);
		wb(1'b1, 8'h00, 32'h00f);
		// timer a pending and unmasked, but no instruction has run yet
		@(posedge sys_clk);
		periph_events <= 21'h1;
		@(posedge sys_clk);
		periph_events <= 21'h0;
		unmask_core();
		repeat (12) @(posedge sys_clk);
		check("before first instr", exc_req, 1'b0);
		run <= 1'b1;
		wait_exc(1'b1, 30);
		check("timer a vector", exc_vector_num, 5'h0a);
		wait_exc(1'b0, 30);
		wb(1'b1, 8'h10, 32'hfffffffe);
		wb(1'b0, 8'h10, 32'h0);
		check("flag cleared", rd, 32'h0);
		// every source at once while masked; one pin pulse gives one edge of each sense
		@(posedge sys_clk);
		{prio_pins, shared_pins} <= 12'h000;
		periph_events <= 21'h1fffff;
		@(posedge sys_clk);
		periph_events <= 21'h0;
		repeat (4) @(posedge sys_clk);
		{prio_pins, shared_pins} <= 12'hfff;
		repeat (10) @(posedge sys_clk);
		check("masked", exc_req, 1'b0);
		wb(1'b1, 8'h0c, 32'hffffffff);
		wb(1'b0, 8'h0c, 32'h0);
		check("ext flags", rd, 32'hfff);
		wb(1'b0, 8'h10, 32'h0);
		check("periph flags", rd, 32'h1fffff);
		// service groups in priority order, clearing each group afterwards
		for (int g = 0; g < 13; g++) begin
			slow <= g[0];
			unmask_core();
			wait_exc(1'b1, 40);
			check("vector", exc_vector_num, exp_vec[g]);
			check("vector addr", exc_vector_addr, {exp_vec[g], 1'b0});
			wait_exc(1'b0, 40);
			wb(1'b1, 8'h0c, ~{20'h0, grp_ext[g]});
			wb(1'b1, 8'h10, ~{11'h0, grp_int[g]});
		end
		// watchdog: overflow resets, next overflow starts reset handling
		wb(1'b1, 8'h14, 32'h1);
		for (int n = 0; n < 40 && core_reset !== 1'b1; n++) @(posedge sys_clk);
		check("wdt reset", core_reset, 1'b1);
		wb(1'b0, 8'h14, 32'h0);
		check("wdt flag", rd[1:0], 2'b11);
		wb(1'b0, 8'h04, 32'h0);
		check("enables cleared", rd, 32'h0);
		wait_exc(1'b1, 60);
		check("wdt vector", exc_vector_num, 5'h00);
		wb(1'b1, 8'h14, 32'h0);
		wait_exc(1'b0, 30);
		wb(1'b0, 8'h14, 32'h0);
		check("wdt flag clear", rd[1:0], 2'b00);
		// pin reset in mid-run clears configuration
		wb(1'b1, 8'h00, 32'h00f);
		pin_reset();
		wb(1'b0, 8'h00, 32'h0);
		check("edge sel reset", rd, 32'h0);
		end_of_test();
	end
endmodule
